/* File: hw/jtids_top.sv */
// Purpose: test port controller, instruction decode and data chains
// Assumes: tck_in is free of glitches; pads and debug port on clk_in
// Notes: link logic on tck_in, pad and debug side on clk_in
`timescale 1ns/1ps

// Functional notes
// RULE1: four-bit instruction chain between tdi and tdo, with a held copy.
// RULE2: shifted instruction becomes active only at the update step.
// RULE3: codes 0000, 0001, 0010 select pad test, core test, sample.
// RULE4: codes 1000, 1010, 1011 select abort, debug access, port access chains.
// RULE5: code 1110 selects identification, 1111 selects one-stage bypass.
// RULE6: every undefined code behaves exactly as bypass.
// RULE7: pad test drives pads from held boundary output and enable bits.
// RULE8: boundary chain stays usable during pad test and core test.
// RULE9: core test feeds the core from held boundary input bits.
// RULE10: reset pin cell is observe only, never driven.
// RULE11: sample captures input, output, enable of every pad at capture.
// RULE12: shift moves captured bits out on tdo while tdi bits enter.
// RULE13: update copies shifted boundary bits into the held registers.
// RULE14: abort instruction puts the abort chain between tdi and tdo.
// RULE15: debug access instruction puts its chain between tdi and tdo.
// RULE16: port access instruction puts its chain between tdi and tdo.
// RULE17: instruction resets to identification on power-on, trst, reset state.
// RULE18: bypass chain is exactly one stage long.
// RULE19: test pins come up in test function after any reset; only rst_n_in resets the pin select, not por_n_in or trst_n_in.
// RULE20: controller restores alternate function before resuming test access; code just sets the select to ~pin_gpio_request_in.
// RULE21: nothing here is reachable over a bus; all access is serial.
// RULE22: identification chain is 32 bits with its lowest bit 1.
// RULE23: bypass captures 0 as its lowest bit.
// RULE24: three cells per pad: input, output, enable; nearest pad first.
// RULE25: abort and both access chains are 35 bits long.
// RULE26: standard sixteen-state controller on tms at rising tck, tdo on falling.
module jtids_top #(
  parameter logic [31:0] IDCODE_VALUE = 32'h1000_0001 // arbitrary value
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic tck_in,
  input wire logic por_n_in,
  input wire logic trst_n_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  output logic tdo_out,
  output logic tdo_oe_n_out,
  input wire logic [jtids_pkg::NPADS-1:0] pad_in_in,
  input wire logic [jtids_pkg::NPADS-1:0] core_out_in,
  input wire logic [jtids_pkg::NPADS-1:0] core_oe_in,
  output logic [jtids_pkg::NPADS-1:0] pad_out_out,
  output logic [jtids_pkg::NPADS-1:0] pad_oe_out,
  output logic [jtids_pkg::NPADS-1:0] core_in_out,
  input wire logic [jtids_pkg::ACC_W-1:0] dbg_rdata_in,
  input wire logic dbg_rvalid_in,
  output logic [jtids_pkg::ACC_W-1:0] dbg_wdata_out,
  output logic [jtids_pkg::CH_W-1:0] dbg_chain_out,
  output logic dbg_req_out,
  input wire logic [jtids_pkg::TEST_PINS-1:0] pin_gpio_request_in,
  output logic [jtids_pkg::TEST_PINS-1:0] pin_alt_function_select_out
);
  // ==========================================
  // declarations
  logic tap_rst_n;
  jtids_pkg::jtids_state_type st_ff;
  logic [jtids_pkg::INS_W-1:0] ins_sh_ff;
  logic [jtids_pkg::INS_W-1:0] ins_ff;
  jtids_pkg::jtids_sel_type sel;
  logic [jtids_pkg::DR_W-1:0] dr_ff;
  logic [jtids_pkg::DR_W-1:0] nxt_dr;
  logic [jtids_pkg::BSR_W-1:0] bsr_ff;
  logic [jtids_pkg::PAD_BITS-1:0] bsr_upd_ff;
  logic [jtids_pkg::BSR_W-1:0] obs_s1_ff;
  logic [jtids_pkg::BSR_W-1:0] obs_s2_ff;
  logic [jtids_pkg::ACC_W-1:0] acc_word_ff;
  logic [jtids_pkg::CH_W-1:0] acc_ch_ff;
  logic acc_tog_ff;
  logic [jtids_pkg::ACC_W-1:0] acc_res_ff;
  logic [2:0] rtog_t_ff;
  logic ex_ff;
  logic in_ff;
  logic [1:0] ex_c_ff;
  logic [1:0] in_c_ff;
  logic [jtids_pkg::PAD_BITS-1:0] upd_s1_ff;
  logic [jtids_pkg::PAD_BITS-1:0] upd_s2_ff;
  logic [jtids_pkg::NPADS-1:0] pin_s1_ff;
  logic [jtids_pkg::NPADS-1:0] pin_s2_ff;
  logic [jtids_pkg::PAD_BITS-1:0] obs_c_ff;
  logic [2:0] wtog_c_ff;
  logic [jtids_pkg::ACC_W-1:0] rhold_ff;
  logic rtog_c_ff;

  assign tap_rst_n = por_n_in & trst_n_in;
  assign sel = jtids_pkg::decode(ins_ff); // RULE3 RULE4 RULE5 RULE6

  // ==========================================
  // controller state, tck domain
  always_ff @(posedge tck_in or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      st_ff <= jtids_pkg::TS_RESET;
    end else begin
      st_ff <= jtids_pkg::tap_next(st_ff, tms_in); // RULE26
    end
  end

  // ==========================================
  // instruction chain and held instruction
  always_ff @(posedge tck_in or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      ins_sh_ff <= jtids_pkg::INS_CAPTURE;
    end else if (st_ff == jtids_pkg::TS_CAP_IR) begin
      ins_sh_ff <= jtids_pkg::INS_CAPTURE;
    end else if (st_ff == jtids_pkg::TS_SH_IR) begin
      ins_sh_ff <= {tdi_in, ins_sh_ff[jtids_pkg::INS_W-1:1]}; // RULE1
    end
  end

  always_ff @(posedge tck_in or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      ins_ff <= jtids_pkg::INS_IDCODE; // RULE17
    end else if (st_ff == jtids_pkg::TS_RESET) begin
      ins_ff <= jtids_pkg::INS_IDCODE; // RULE17
    end else if (st_ff == jtids_pkg::TS_UPD_IR) begin
      ins_ff <= ins_sh_ff; // RULE2
    end
  end

  // ==========================================
  // shared chain: identification, bypass, debug words
  always_comb begin
    nxt_dr = dr_ff;
    if (st_ff == jtids_pkg::TS_CAP_DR) begin
      case (sel)
        jtids_pkg::SEL_ID: nxt_dr = {{(jtids_pkg::DR_W-jtids_pkg::ID_W){1'b0}},
                                     IDCODE_VALUE[jtids_pkg::ID_W-1:1], 1'b1}; // RULE22
        jtids_pkg::SEL_ABORT, jtids_pkg::SEL_DP,
        jtids_pkg::SEL_AP: nxt_dr = acc_res_ff;
        default: nxt_dr = {{(jtids_pkg::DR_W-1){1'b0}},
                           jtids_pkg::BYP_CAPTURE}; // RULE23
      endcase
    end else if (st_ff == jtids_pkg::TS_SH_DR) begin
      // length follows the selected chain, tdi enters at its top stage
      nxt_dr = dr_ff >> 1;
      nxt_dr[jtids_pkg::chain_len(sel)-1] = tdi_in; // RULE18 RULE25
    end
  end

  always_ff @(posedge tck_in or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      dr_ff <= '0;
    end else begin
      dr_ff <= nxt_dr;
    end
  end

  // ==========================================
  // boundary chain
  always_ff @(posedge tck_in or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      bsr_ff <= '0;
    end else if (sel == jtids_pkg::SEL_BSR) begin // RULE8
      if (st_ff == jtids_pkg::TS_CAP_DR) begin
        bsr_ff <= obs_s2_ff; // RULE11 RULE24
      end else if (st_ff == jtids_pkg::TS_SH_DR) begin
        bsr_ff <= {tdi_in, bsr_ff[jtids_pkg::BSR_W-1:1]}; // RULE12
      end
    end
  end

  // reset pin cell sits on top and is left out of the held copy
  always_ff @(posedge tck_in or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      bsr_upd_ff <= '0;
    end else if (sel == jtids_pkg::SEL_BSR && st_ff == jtids_pkg::TS_UPD_DR) begin
      bsr_upd_ff <= bsr_ff[jtids_pkg::PAD_BITS-1:0]; // RULE13 RULE10
    end
  end

  always_ff @(posedge tck_in or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      ex_ff <= 1'b0;
      in_ff <= 1'b0;
    end else if (st_ff == jtids_pkg::TS_RESET) begin
      ex_ff <= 1'b0;
      in_ff <= 1'b0;
    end else if (st_ff == jtids_pkg::TS_UPD_IR) begin
      // set from the shifted code: tck may stop right after the update
      ex_ff <= (ins_sh_ff == jtids_pkg::INS_EXTEST); // RULE7
      in_ff <= (ins_sh_ff == jtids_pkg::INS_INTEST); // RULE9
    end
  end

  // pad observations cross as quasi-static levels
  always_ff @(posedge tck_in or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      obs_s1_ff <= '0;
      obs_s2_ff <= '0;
    end else begin
      obs_s1_ff <= {rst_n_in, obs_c_ff}; // RULE10
      obs_s2_ff <= obs_s1_ff;
    end
  end

  // ==========================================
  // debug word hand-off toward the debug port
  // only power-on clears the toggle: a test reset must not fake a request
  always_ff @(posedge tck_in or negedge por_n_in) begin
    if (!por_n_in) begin
      acc_word_ff <= '0;
      acc_ch_ff <= jtids_pkg::CH_ABORT;
      acc_tog_ff <= 1'b0;
    end else if (st_ff == jtids_pkg::TS_UPD_DR) begin
      case (sel)
        jtids_pkg::SEL_ABORT: begin
          acc_word_ff <= dr_ff; // RULE14
          acc_ch_ff <= jtids_pkg::CH_ABORT;
          acc_tog_ff <= ~acc_tog_ff;
        end
        jtids_pkg::SEL_DP: begin
          acc_word_ff <= dr_ff; // RULE15
          acc_ch_ff <= jtids_pkg::CH_DP;
          acc_tog_ff <= ~acc_tog_ff;
        end
        jtids_pkg::SEL_AP: begin
          acc_word_ff <= dr_ff; // RULE16
          acc_ch_ff <= jtids_pkg::CH_AP;
          acc_tog_ff <= ~acc_tog_ff;
        end
        default: acc_tog_ff <= acc_tog_ff;
      endcase
    end
  end

  // result word is stable in rhold_ff when its toggle arrives
  always_ff @(posedge tck_in or negedge por_n_in) begin
    if (!por_n_in) begin
      rtog_t_ff <= '0;
      acc_res_ff <= '0;
    end else begin
      rtog_t_ff <= {rtog_t_ff[1:0], rtog_c_ff};
      if (rtog_t_ff[2] != rtog_t_ff[1]) begin
        acc_res_ff <= rhold_ff;
      end
    end
  end

  // ==========================================
  // serial output on the falling edge
  always_ff @(negedge tck_in or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      tdo_out <= 1'b0;
      tdo_oe_n_out <= 1'b1;
    end else begin
      tdo_oe_n_out <= !(st_ff == jtids_pkg::TS_SH_IR || st_ff == jtids_pkg::TS_SH_DR);
      if (st_ff == jtids_pkg::TS_SH_IR) begin
        tdo_out <= ins_sh_ff[0]; // RULE1 RULE26
      end else if (sel == jtids_pkg::SEL_BSR) begin
        tdo_out <= bsr_ff[0]; // RULE21
      end else begin
        tdo_out <= dr_ff[0]; // RULE6
      end
    end
  end

  // ==========================================
  // clk domain: crossings in
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ex_c_ff <= '0;
      in_c_ff <= '0;
      upd_s1_ff <= '0;
      upd_s2_ff <= '0;
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      wtog_c_ff <= '0;
    end else begin
      ex_c_ff <= {ex_c_ff[0], ex_ff};
      in_c_ff <= {in_c_ff[0], in_ff};
      upd_s1_ff <= bsr_upd_ff;
      upd_s2_ff <= upd_s1_ff;
      pin_s1_ff <= pad_in_in;
      pin_s2_ff <= pin_s1_ff;
      wtog_c_ff <= {wtog_c_ff[1:0], acc_tog_ff};
    end
  end

  // ==========================================
  // pad and core muxing
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pad_out_out <= '0;
      pad_oe_out <= '0;
    end else if (ex_c_ff[1]) begin
      pad_out_out <= jtids_pkg::cells(upd_s2_ff, jtids_pkg::CELL_OUT); // RULE7
      pad_oe_out <= jtids_pkg::cells(upd_s2_ff, jtids_pkg::CELL_OE); // RULE7
    end else begin
      pad_out_out <= core_out_in;
      pad_oe_out <= core_oe_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      core_in_out <= '0;
    end else if (in_c_ff[1]) begin
      core_in_out <= jtids_pkg::cells(upd_s2_ff, jtids_pkg::CELL_IN); // RULE9
    end else begin
      core_in_out <= pin_s2_ff;
    end
  end

  // cell triples per pad, pad 0 nearest the test pins
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      obs_c_ff <= '0;
    end else begin
      for (int p = 0; p < jtids_pkg::NPADS; p++) begin
        obs_c_ff[jtids_pkg::CELLS*p+jtids_pkg::CELL_IN] <= pin_s2_ff[p]; // RULE24
        obs_c_ff[jtids_pkg::CELLS*p+jtids_pkg::CELL_OUT] <= pad_out_out[p];
        obs_c_ff[jtids_pkg::CELLS*p+jtids_pkg::CELL_OE] <= pad_oe_out[p];
      end
    end
  end

  // ==========================================
  // debug port request and result
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dbg_req_out <= 1'b0;
      dbg_wdata_out <= '0;
      dbg_chain_out <= jtids_pkg::CH_ABORT;
    end else begin
      dbg_req_out <= wtog_c_ff[2] ^ wtog_c_ff[1];
      if (wtog_c_ff[2] ^ wtog_c_ff[1]) begin
        dbg_wdata_out <= acc_word_ff;
        dbg_chain_out <= acc_ch_ff;
      end
    end
  end

  // a second result before the first has crossed overwrites it
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rhold_ff <= '0;
      rtog_c_ff <= 1'b0;
    end else if (dbg_rvalid_in) begin
      rhold_ff <= dbg_rdata_in;
      rtog_c_ff <= ~rtog_c_ff;
    end
  end

  // pins follow the alternate function unless the core asks for them
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_alt_function_select_out <= jtids_pkg::ALT_ALL; // RULE19
    end else begin
      pin_alt_function_select_out <= ~pin_gpio_request_in; // RULE20
    end
  end

  // ==========================================
  // checks
  sequence s_byp_cap;
    sel == jtids_pkg::SEL_BYP && st_ff == jtids_pkg::TS_CAP_DR;
  endsequence
  sequence s_ir_load;
    st_ff == jtids_pkg::TS_UPD_IR ##1 st_ff != jtids_pkg::TS_RESET;
  endsequence

  a_ir_reset_id: assert property (@(posedge tck_in) disable iff (!tap_rst_n) // RULE17
    st_ff == jtids_pkg::TS_RESET |=> ins_ff == jtids_pkg::INS_IDCODE)
    else $error("instruction not identification after reset state");
  a_ir_update_load: assert property (@(posedge tck_in) disable iff (!tap_rst_n) // RULE2
    s_ir_load |-> ins_ff == $past(ins_sh_ff, 2))
    else $error("instruction not loaded at update");
  a_ir_hold_stable: assert property (@(posedge tck_in) disable iff (!tap_rst_n) // RULE1
    st_ff inside {jtids_pkg::TS_SH_IR, jtids_pkg::TS_CAP_IR} |=> $stable(ins_ff))
    else $error("instruction changed before update");
  a_byp_one_stage: assert property (@(posedge tck_in) disable iff (!tap_rst_n) // RULE18
    s_byp_cap ##1 st_ff == jtids_pkg::TS_SH_DR |=> dr_ff[0] == $past(tdi_in))
    else $error("bypass path is not one stage");
  a_byp_capture_zero: assert property (@(posedge tck_in) disable iff (!tap_rst_n) // RULE23
    s_byp_cap |=> dr_ff[0] == jtids_pkg::BYP_CAPTURE)
    else $error("bypass capture is not zero");
  a_id_capture_val: assert property (@(posedge tck_in) disable iff (!tap_rst_n) // RULE22
    sel == jtids_pkg::SEL_ID && st_ff == jtids_pkg::TS_CAP_DR
    |=> dr_ff[jtids_pkg::ID_W-1:1] == IDCODE_VALUE[jtids_pkg::ID_W-1:1] && dr_ff[0])
    else $error("identification capture wrong");
  a_bsr_update_copy: assert property (@(posedge tck_in) disable iff (!tap_rst_n) // RULE13
    sel == jtids_pkg::SEL_BSR && st_ff == jtids_pkg::TS_UPD_DR
    |=> bsr_upd_ff == $past(bsr_ff[jtids_pkg::PAD_BITS-1:0]))
    else $error("boundary update copy wrong");
  a_bsr_shift_path: assert property (@(posedge tck_in) disable iff (!tap_rst_n) // RULE12
    sel == jtids_pkg::SEL_BSR && st_ff == jtids_pkg::TS_SH_DR
    |=> bsr_ff[jtids_pkg::BSR_W-1] == $past(tdi_in) && bsr_ff[0] == $past(bsr_ff[1]))
    else $error("boundary shift wrong");
  a_extest_pad_drive: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE7
    ex_c_ff[1] |=> pad_oe_out == jtids_pkg::cells($past(upd_s2_ff), jtids_pkg::CELL_OE))
    else $error("pad enable not from boundary data");
  a_intest_core_in: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE9
    in_c_ff[1] |=> core_in_out == jtids_pkg::cells($past(upd_s2_ff), jtids_pkg::CELL_IN))
    else $error("core input not from boundary data");
  a_tdo_enable_shift: assert property (@(negedge tck_in) disable iff (!tap_rst_n) // RULE26
    st_ff == jtids_pkg::TS_SH_DR |=> !tdo_oe_n_out)
    else $error("tdo not driven in shift");
endmodule : jtids_top

/* File: hw/jtids_pkg.sv */
// Purpose: constants, types and helpers for the test port decode and chains
// Assumes: one boundary cell triple per pad, one capture-only reset cell
// Notes: used by the design; the bench keeps its own copies of codes and lengths
package jtids_pkg;
  // ==========================================
  // instruction codes
  localparam int INS_W = 4;
  localparam logic [3:0] INS_EXTEST = 4'h0;
  localparam logic [3:0] INS_INTEST = 4'h1;
  localparam logic [3:0] INS_SAMPLE = 4'h2;
  localparam logic [3:0] INS_ABORT = 4'h8;
  localparam logic [3:0] INS_DP_ACC = 4'ha;
  localparam logic [3:0] INS_AP_ACC = 4'hb;
  localparam logic [3:0] INS_IDCODE = 4'he;
  localparam logic [3:0] INS_BYPASS = 4'hf;
  // fixed pattern seen in the capture step of the instruction chain
  localparam logic [3:0] INS_CAPTURE = 4'h1;
  // ==========================================
  // chain geometry
  localparam int ID_W = 32;
  localparam int ACC_W = 35;
  localparam int DR_W = 35;
  localparam int BYP_W = 1;
  localparam logic BYP_CAPTURE = 1'b0;
  localparam int NPADS = 8;
  localparam int CELLS = 3;
  localparam int CELL_IN = 0;
  localparam int CELL_OUT = 1;
  localparam int CELL_OE = 2;
  localparam int PAD_BITS = CELLS * NPADS;
  localparam int BSR_W = PAD_BITS + 1;
  localparam int TEST_PINS = 5;
  localparam logic [4:0] ALT_ALL = 5'h1f;
  localparam int CH_W = 2;
  localparam logic [1:0] CH_ABORT = 2'h0;
  localparam logic [1:0] CH_DP = 2'h1;
  localparam logic [1:0] CH_AP = 2'h2;
  // ==========================================
  // types
  typedef enum logic [3:0] {
    TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SH_DR, TS_EX1_DR,
    TS_PA_DR, TS_EX2_DR, TS_UPD_DR, TS_SEL_IR, TS_CAP_IR, TS_SH_IR,
    TS_EX1_IR, TS_PA_IR, TS_EX2_IR, TS_UPD_IR
  } jtids_state_type;
  typedef enum logic [2:0] {
    SEL_BSR, SEL_ABORT, SEL_DP, SEL_AP, SEL_ID, SEL_BYP
  } jtids_sel_type;
  // ==========================================
  // helpers
  function automatic jtids_state_type tap_next(jtids_state_type s, logic tms);
    jtids_state_type n;
    n = TS_RESET;
    case (s)
      TS_RESET: n = tms ? TS_RESET : TS_IDLE;
      TS_IDLE: n = tms ? TS_SEL_DR : TS_IDLE;
      TS_SEL_DR: n = tms ? TS_SEL_IR : TS_CAP_DR;
      TS_CAP_DR: n = tms ? TS_EX1_DR : TS_SH_DR;
      TS_SH_DR: n = tms ? TS_EX1_DR : TS_SH_DR;
      TS_EX1_DR: n = tms ? TS_UPD_DR : TS_PA_DR;
      TS_PA_DR: n = tms ? TS_EX2_DR : TS_PA_DR;
      TS_EX2_DR: n = tms ? TS_UPD_DR : TS_SH_DR;
      TS_UPD_DR: n = tms ? TS_SEL_DR : TS_IDLE;
      TS_SEL_IR: n = tms ? TS_RESET : TS_CAP_IR;
      TS_CAP_IR: n = tms ? TS_EX1_IR : TS_SH_IR;
      TS_SH_IR: n = tms ? TS_EX1_IR : TS_SH_IR;
      TS_EX1_IR: n = tms ? TS_UPD_IR : TS_PA_IR;
      TS_PA_IR: n = tms ? TS_EX2_IR : TS_PA_IR;
      TS_EX2_IR: n = tms ? TS_UPD_IR : TS_SH_IR;
      TS_UPD_IR: n = tms ? TS_SEL_DR : TS_IDLE;
      default: n = TS_RESET;
    endcase
    return n;
  endfunction : tap_next

  function automatic jtids_sel_type decode(logic [3:0] c);
    jtids_sel_type r;
    r = SEL_BYP;
    case (c)
      INS_EXTEST, INS_INTEST, INS_SAMPLE: r = SEL_BSR;
      INS_ABORT: r = SEL_ABORT;
      INS_DP_ACC: r = SEL_DP;
      INS_AP_ACC: r = SEL_AP;
      INS_IDCODE: r = SEL_ID;
      default: r = SEL_BYP;
    endcase
    return r;
  endfunction : decode

  function automatic int chain_len(jtids_sel_type s);
    int n;
    n = BYP_W;
    case (s)
      SEL_ID: n = ID_W;
      SEL_ABORT, SEL_DP, SEL_AP: n = ACC_W;
      default: n = BYP_W;
    endcase
    return n;
  endfunction : chain_len

  function automatic logic [NPADS-1:0] cells(logic [PAD_BITS-1:0] v, int k);
    logic [NPADS-1:0] r;
    r = '0;
    for (int p = 0; p < NPADS; p++) begin
      r[p] = v[CELLS*p+k];
    end
    return r;
  endfunction : cells
endpackage : jtids_pkg

/* File: dv/jtids_probe.sv */
// Purpose: behavioural debug probe on the far side of the test port
// Assumes: test clock stands still between frames, 6 ns period
// Notes: the bench calls the tasks by instance name
`timescale 1ns/1ps
module jtids_probe (
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out,
  output logic trst_n_out,
  input wire logic tdo_in
);
  // ==========================================
  // reset and one test clock
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b0;
    trst_n_out = 1'b0;
    #60 trst_n_out = 1'b1;
  end

  // tdo is sampled at the rising edge, launched at the falling one
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tms_out = tms;
    tdi_out = tdi;
    #3;
    tdo = tdo_in;
    tck_out = 1'b1;
    #3;
    tck_out = 1'b0;
  endtask : step

  task automatic to_idle();
    logic d;
    for (int i = 0; i < 5; i++) begin
      step(1'b1, 1'b0, d);
    end
    step(1'b0, 1'b1, d);
  endtask : to_idle

  // ==========================================
  // idle to idle: capture, n shifts lsb first, update
  task automatic scan(input logic ir, input int n, input logic [63:0] din,
                      output logic [63:0] dout);
    logic d;
    dout = '0;
    step(1'b1, 1'b0, d);
    if (ir) begin
      step(1'b1, 1'b1, d);
    end
    step(1'b0, 1'b0, d);
    step(1'b0, 1'b1, d);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], dout[i]);
    end
    // tdi no longer sampled: keep it moving
    step(1'b1, ~din[n-1], d);
    step(1'b0, din[n-1], d);
  endtask : scan

  // idle clocks let a result cross before the next capture
  task automatic run_idle(input int n);
    logic d;
    for (int i = 0; i < n; i++) begin
      step(1'b0, 1'b0, d);
    end
  endtask : run_idle

  // test reset in mid-run, then one clock into idle
  task automatic pulse_trst();
    logic d;
    trst_n_out = 1'b0;
    #6;
    trst_n_out = 1'b1;
    step(1'b0, 1'b0, d);
  endtask : pulse_trst
endmodule : jtids_probe

/* File: dv/testbench.sv */
// Purpose: self-checking bench for the test port decode and chains
// Assumes: probe model drives the link, bench drives the clk side
// Notes: length of every chain found by how late the pattern returns
`timescale 1ns/1ps
module testbench;
  localparam logic [31:0] ID = 32'h2468_ace1; // arbitrary value
  localparam logic [63:0] PAT = 64'h0000_96f0_0f69_5a3c;
  localparam logic [23:0] PRE = 24'hc3_5a69;
  typedef struct packed {logic [3:0] code; logic [7:0] len;} jtids_row_type;
  jtids_row_type rows [16] = '{'{4'h0, 8'h19}, '{4'h1, 8'h19}, '{4'h2, 8'h19},
    '{4'h3, 8'h01}, '{4'h4, 8'h01}, '{4'h5, 8'h01}, '{4'h6, 8'h01},
    '{4'h7, 8'h01}, '{4'h8, 8'h23}, '{4'h9, 8'h01}, '{4'ha, 8'h23},
    '{4'hb, 8'h23}, '{4'hc, 8'h01}, '{4'hd, 8'h01}, '{4'he, 8'h20},
    '{4'hf, 8'h01}};
  logic clk_in = 1'b0;
  logic rst_n_in, por_n_in, tck, tms, tdi, trst_n, tdo, tdo_oe_n;
  logic [7:0] pad_in, core_out, core_oe, pad_out, pad_oe, core_in;
  logic [34:0] rdata, wdata, got_w;
  logic rvalid, req;
  logic [1:0] chain, got_c;
  logic [4:0] gpio_req, alt_sel;
  logic [63:0] q, exp, pre;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;

  always #12.5 clk_in = ~clk_in;

  jtids_probe P (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .trst_n_out(trst_n),
    .tdo_in(tdo));

  jtids_top #(.IDCODE_VALUE(ID)) DUT (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .tck_in(tck), .por_n_in(por_n_in), .trst_n_in(trst_n), .tms_in(tms),
    .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_n_out(tdo_oe_n), .pad_in_in(pad_in),
    .core_out_in(core_out), .core_oe_in(core_oe), .pad_out_out(pad_out),
    .pad_oe_out(pad_oe), .core_in_out(core_in), .dbg_rdata_in(rdata),
    .dbg_rvalid_in(rvalid), .dbg_wdata_out(wdata), .dbg_chain_out(chain),
    .dbg_req_out(req), .pin_gpio_request_in(gpio_req),
    .pin_alt_function_select_out(alt_sel));

  // ==========================================
  // checking and closing
  task automatic chk(input logic [63:0] got, input logic [63:0] want);
    check_count++;
    if (got !== want) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : chk

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  // request words are one clk pulses: catch them here
  always @(posedge clk_in) begin
    cycles++;
    if (req === 1'b1) begin
      got_w <= wdata;
      got_c <= chain;
    end
    if (cycles == 20000) begin
      fail_count++;
      final_report();
    end
  end

  // ==========================================
  // main sequence
  initial begin
    {rst_n_in, por_n_in, rvalid, rdata, gpio_req} = '0;
    {pad_in, core_out, core_oe} = '0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    por_n_in <= 1'b1;
    pad_in <= 8'h96;
    core_out <= 8'ha5;
    core_oe <= 8'h3c;
    repeat (4) @(posedge clk_in);
    chk(alt_sel, 5'h1f);
    P.to_idle();
    chk(tdo_oe_n, 1'b1);
    P.scan(1'b0, 32, '0, q);
    chk(q, ID);
    for (int r = 0; r < 16; r++) begin
      P.scan(1'b1, 4, {60'h0, rows[r].code}, q);
      chk(q, 64'h1);
      P.scan(1'b0, 48, PAT, q);
      chk((q >> rows[r].len) & 64'hff, PAT & 64'hff);
      if (rows[r].len == 8'h01) chk(q[0], 1'b0);
      if (rows[r].len == 8'h20) chk(q[31:0], ID);
    end
    P.to_idle();
    P.scan(1'b0, 32, '0, q);
    chk(q, ID);
    // preload: in 69, out 5a, enable c3; capture sees pad 96, core a5/3c
    exp = 64'h100_0000;
    pre = '0;
    for (int p = 0; p < 8; p++) begin
      exp[3*p+:3] = {core_oe[p], core_out[p], pad_in[p]};
      pre[3*p+:3] = {PRE[16+p], PRE[8+p], PRE[p]};
    end
    P.scan(1'b1, 4, 64'h2, q);
    P.scan(1'b0, 25, pre, q);
    chk(q, exp);
    P.scan(1'b1, 4, 64'h0, q);
    repeat (8) @(posedge clk_in);
    chk({pad_oe, pad_out}, 16'hc35a);
    P.scan(1'b1, 4, 64'h1, q);
    repeat (8) @(posedge clk_in);
    chk(core_in, 8'h69);
    for (int k = 0; k < 3; k++) begin
      P.scan(1'b1, 4, {60'h0, rows[8 + k + (k > 0)].code}, q);
      P.scan(1'b0, 35, PAT + k, q);
      repeat (12) @(posedge clk_in);
      chk({got_c, got_w}, {k[1:0], PAT[34:0] + 35'(k)});
    end
    @(posedge clk_in);
    rdata <= 35'h5_1234_5678;
    rvalid <= 1'b1;
    @(posedge clk_in);
    rvalid <= 1'b0;
    repeat (8) @(posedge clk_in);
    P.run_idle(4);
    P.scan(1'b0, 35, '0, q);
    chk(q, 64'h5_1234_5678);
    gpio_req <= 5'h05;
    repeat (4) @(posedge clk_in);
    chk(alt_sel, 5'h1a);
    gpio_req <= 5'h00;
    repeat (4) @(posedge clk_in);
    chk(alt_sel, 5'h1f);
    P.pulse_trst();
    P.scan(1'b0, 32, '0, q);
    chk(q, ID);
    final_report();
  end
endmodule : testbench
